// File: spseq_pkg.sv
package spseq_pkg;
    localparam int          NPROG = 15;
    localparam int          NSEG  = 15;
    localparam logic [7:0]  A_CTRL = 8'h00;
    localparam logic [7:0]  A_SEL  = 8'h04;
    localparam logic [7:0]  A_PCFG = 8'h08;
    localparam logic [7:0]  A_SEGL = 8'h0C;
    localparam logic [7:0]  A_SEGH = 8'h10;
    localparam logic [7:0]  A_STAT = 8'h20;
    localparam logic [7:0]  A_ELAP = 8'h24;
    localparam logic [7:0]  A_REMS = 8'h28;
    localparam logic [7:0]  A_REMP = 8'h2C;
    localparam logic [7:0]  A_SP   = 8'h30;
    localparam int          C_SRC  = 0;
    localparam int          C_PRGL = 4;
    localparam int          C_OUTL = 8;
    localparam int          C_STOP = 16;
    localparam logic [13:0] RATE_MIN = 14'h0001;
    localparam logic [13:0] RATE_MAX = 14'h157C;
    localparam logic [15:0] DUR_MIN  = 16'h0001;
    localparam logic [9:0]  REPS_DEF = 10'h001;
    localparam logic [19:0] SEC_MIN  = 20'h0003C;
    localparam logic [19:0] SEC_HOUR = 20'h00E10;
    localparam logic [1:0]  FN_AUX1  = 2'h1;
    localparam logic [1:0]  FN_AUX2  = 2'h2;
    localparam int          TICK_S   = 1;
    localparam int          CLK_MHZ  = 100;
    localparam int          TICK_CYC = TICK_S * CLK_MHZ * 1000000;
    typedef enum logic [1:0] {
        K_TIME = 2'h0, K_RATE = 2'h1, K_DWELL = 2'h2, K_END = 2'h3
    } spseq_kind_t;
    typedef enum logic [1:0] {
        L_OFF = 2'h0, L_LOW = 2'h1, L_HIGH = 2'h2, L_BAND = 2'h3
    } spseq_lock_t;
    typedef struct packed {
        spseq_kind_t  kind;
        logic [1:0]   pid;
        logic         aux2;
        logic         aux1;
        logic [11:0]  lockv;
        logic [13:0]  rate;
        logic [15:0]  dur;
        logic [15:0]  end_sp;
    } spseq_seg_t;
    typedef struct packed {
        logic         pad;
        logic         start_pv;
        logic         tunit_hm;
        logic         runit_hr;
        spseq_lock_t  lmode;
        logic [9:0]   reps;
        logic [15:0]  init_sp;
    } spseq_prog_t;
    localparam spseq_seg_t  SEG_DEF  = '{K_TIME, 2'h0, 1'b0, 1'b0, 12'h000, RATE_MIN, DUR_MIN, 16'h0000};
    localparam spseq_prog_t PROG_DEF = '{1'b0, 1'b0, 1'b0, 1'b0, L_OFF, REPS_DEF, 16'h0000};
endpackage

// File: spseq_div.sv
`timescale 1ns/10ps
`default_nettype none
module spseq_div
    import spseq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [31:0] num,
    input  wire logic [19:0] den,
    output logic      [31:0] quo,
    output logic             done
);
    logic [31:0] q_reg;
    logic [20:0] r_reg;
    logic [5:0]  cnt_reg;
    logic [20:0] trial;

    assign trial = {r_reg[19:0], q_reg[31]} - {1'b0, den};
    assign quo   = q_reg;

    // Restoring division, one quotient bit per cycle; slow but small.
    always_ff @(posedge clk) begin
        if (rst) begin
            q_reg   <= 32'h00000000;
            r_reg   <= 21'h000000;
            cnt_reg <= 6'h00;
            done    <= 1'b0;
        end else if (go) begin
            q_reg   <= num;
            r_reg   <= 21'h000000;
            cnt_reg <= 6'h20;
            done    <= 1'b0;
        end else if (cnt_reg != 6'h00) begin
            cnt_reg <= cnt_reg - 6'h01;
            done    <= (cnt_reg == 6'h01);
            if (!trial[20]) begin
                r_reg <= trial;
                q_reg <= {q_reg[30:0], 1'b1};
            end else begin
                r_reg <= {r_reg[19:0], q_reg[31]};
                q_reg <= {q_reg[30:0], 1'b0};
            end
        end else begin
            done <= 1'b0;
        end
    end
endmodule // spseq_div
`default_nettype wire

// File: spseq_lock.sv
`timescale 1ns/10ps
`default_nettype none
module spseq_lock
    import spseq_pkg::*;
(
    input  wire spseq_lock_t        mode,
    input  wire logic        [11:0] lockv,
    input  wire logic signed [15:0] sp,
    input  wire logic signed [15:0] pv,
    output logic                    locked
);
    logic signed [17:0] lo_lim;
    logic signed [17:0] hi_lim;
    logic               low_hit;
    logic               high_hit;

    assign lo_lim   = 18'(sp) - 18'(signed'({1'b0, lockv}));
    assign hi_lim   = 18'(sp) + 18'(signed'({1'b0, lockv}));
    assign low_hit  = 18'(pv) < lo_lim;
    assign high_hit = 18'(pv) > hi_lim;

    always_comb begin
        locked = 1'b0;
        if (lockv != 12'h000) begin
            unique case (mode)
                L_OFF:  locked = 1'b0;
                L_LOW:  locked = low_hit;
                L_HIGH: locked = high_hit;
                L_BAND: locked = low_hit | high_hit;
            endcase
        end
    end
endmodule // spseq_lock
`default_nettype wire

// File: spseq_top.sv
// Function
// - Fifteen programs of fifteen segments stored.
// - Program parameters accessible only in profile mode.
// - Each segment kind uses only its parameters.
// - Duration counted in hh.mm or mm.ss.
// - Ramp rate 0.1 to 550.0 per unit.
// - Segment selects one of four PID sets.
// - Aux states drive only aux-configured outputs.
// - Profile mode regulates to program set point while running.
// - Button start accepted only stopped or ended.
// - Corner dot steady while running unlocked.
// - Run status readable over the bus.
// - Completion ends or repeats per repetition count.
// - After completion aux follow end segment.
// - Lock checked only with mode and value.
// - Lower lock: value below set point minus lock.
// - Upper lock: value above set point plus lock.
// - Band lock: either lower or upper holds.
// - Lock freezes advance and flashes the dot.
// - Start from initial set point or measurement.
// - Program holds initial set point, default zero.
`timescale 1ns/10ps
`default_nettype none
module spseq_top
    import spseq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        WVALID,
    output logic             WREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    output logic             BVALID,
    input  wire logic        BREADY,
    output logic [1:0]       BRESP,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    input  wire logic [7:0]  ARADDR,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    input  wire logic        BTN_A,
    input  wire logic        BTN_B,
    input  wire logic [15:0] PV,
    output logic [15:0]      SETPOINT,
    output logic             SP_FROM_PROG,
    output logic [1:0]       PID_SEL,
    output logic [2:0]       AUX_OUT,
    output logic             DOT
);
    typedef enum logic [2:0] {
        S_STOP = 3'h0, S_LOAD = 3'h1, S_DIV = 3'h2, S_RUN = 3'h3, S_END = 3'h4
    } spseq_state_t;

    spseq_seg_t   seg_mem [NPROG*NSEG];
    spseq_prog_t  prg_mem [NPROG];
    spseq_state_t st_reg;
    logic [31:0]  ctrl_reg;
    logic [7:0]   sel_reg;
    logic [31:0]  segl_reg;
    logic [7:0]   aw_reg;
    logic [31:0]  wd_reg;
    logic [3:0]   ws_reg;
    logic         aw_have_reg;
    logic         w_have_reg;
    logic [31:0]  rd_next;
    logic         rd_ok;
    logic         wr_ok;
    logic         wr_go;
    logic [31:0]  wmask;
    logic [31:0]  tick_cnt_reg;
    logic         tick_reg;
    logic         blink_reg;
    logic [1:0]   ba_sync_reg;
    logic [1:0]   bb_sync_reg;
    logic         both_reg;
    logic [3:0]   prg_idx_reg;
    logic [3:0]   seg_idx_reg;
    logic [9:0]   reps_reg;
    logic signed [23:0] sp_reg;
    logic [31:0]  step_reg;
    logic         neg_reg;
    logic [19:0]  elap_reg;
    logic [19:0]  dur_reg;
    logic         aux1_reg;
    logic         aux2_reg;
    logic [1:0]   pid_reg;
    logic         locked;
    logic         prof;
    logic [3:0]   cfg_prog;
    logic         btn_start;
    logic         div_go;
    logic [31:0]  div_q;
    logic         div_done;
    logic [31:0]  div_num;
    logic [19:0]  div_den;
    logic signed [16:0] delta;
    logic [31:0]  rem_prog;
    spseq_seg_t   cur;
    spseq_prog_t  pcfg;
    spseq_seg_t   sel_seg;
    spseq_prog_t  sel_prog;

    // Duration in seconds: hh.mm counts minutes, mm.ss counts seconds.
    function automatic logic [19:0] dur_sec(input logic [15:0] d, input logic hm);
        logic [19:0] u;
        u = 20'(d[15:8]) * SEC_MIN + 20'(d[7:0]);
        return hm ? 20'(u * SEC_MIN) : u;
    endfunction

    assign prof     = ctrl_reg[C_SRC];
    assign cfg_prog = (ctrl_reg[C_PRGL+3:C_PRGL] == 4'h0) ? 4'h0 : ctrl_reg[C_PRGL+3:C_PRGL] - 4'h1;
    assign cur      = seg_mem[8'(prg_idx_reg) * 8'(NSEG) + 8'(seg_idx_reg)];
    assign pcfg     = prg_mem[prg_idx_reg];
    assign sel_seg  = seg_mem[8'(sel_reg[7:4]) * 8'(NSEG) + 8'(sel_reg[3:0])];
    assign sel_prog = prg_mem[sel_reg[7:4]];
    assign delta    = 17'(signed'(cur.end_sp)) - 17'(signed'(sp_reg[23:8]));

    // AXI4-Lite write side: address and data taken in either order.
    assign AWREADY = !aw_have_reg && !BVALID;
    assign WREADY  = !w_have_reg && !BVALID;
    assign wr_go   = aw_have_reg && w_have_reg && !BVALID;
    assign wr_ok   = (aw_reg <= A_SEGH) && (aw_reg[1:0] == 2'h0);
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = ws_reg[b] ? 8'hFF : 8'h00;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_reg      <= 8'h00;
            wd_reg      <= 32'h00000000;
            ws_reg      <= 4'h0;
            BVALID      <= 1'b0;
            BRESP       <= 2'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_reg      <= AWADDR;
                aw_have_reg <= 1'b1;
            end
            if (WVALID && WREADY) begin
                wd_reg     <= WDATA;
                ws_reg     <= WSTRB;
                w_have_reg <= 1'b1;
            end
            if (wr_go) begin
                BVALID      <= 1'b1;
                BRESP       <= wr_ok ? 2'h0 : 2'h2;
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // Configuration store; program parameters are hidden outside profile mode.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ctrl_reg <= 32'h00000000;
            sel_reg  <= 8'h00;
            segl_reg <= 32'h00000000;
            for (int i = 0; i < NPROG*NSEG; i++) begin
                seg_mem[i] <= SEG_DEF;
            end
            for (int i = 0; i < NPROG; i++) begin
                prg_mem[i] <= PROG_DEF;
            end
        end else begin
            ctrl_reg[C_STOP] <= 1'b0;
            if (wr_go && aw_reg == A_CTRL) begin
                ctrl_reg <= (ctrl_reg & ~wmask) | (wd_reg & wmask);
            end
            if (wr_go && aw_reg == A_SEL && ws_reg[0] && prof) begin
                sel_reg <= (wd_reg[7:4] < 4'(NPROG) && wd_reg[3:0] < 4'(NSEG)) ? wd_reg[7:0] : sel_reg;
            end
            if (wr_go && aw_reg == A_PCFG && prof) begin
                prg_mem[sel_reg[7:4]] <= (sel_prog & ~wmask) | (wd_reg & wmask);
                if (wd_reg[25:16] == 10'h000 && ws_reg[2]) begin
                    prg_mem[sel_reg[7:4]].reps <= REPS_DEF;
                end
            end
            if (wr_go && aw_reg == A_SEGL && prof) begin
                segl_reg <= (segl_reg & ~wmask) | (wd_reg & wmask);
            end
            if (wr_go && aw_reg == A_SEGH && prof) begin
                seg_mem[8'(sel_reg[7:4]) * 8'(NSEG) + 8'(sel_reg[3:0])] <= {(wd_reg & wmask), segl_reg};
                if (wd_reg[13:0] < RATE_MIN || wd_reg[13:0] > RATE_MAX) begin
                    seg_mem[8'(sel_reg[7:4]) * 8'(NSEG) + 8'(sel_reg[3:0])].rate <= RATE_MIN;
                end
                if (segl_reg[31:16] < DUR_MIN) begin
                    seg_mem[8'(sel_reg[7:4]) * 8'(NSEG) + 8'(sel_reg[3:0])].dur <= DUR_MIN;
                end
            end
        end
    end

    // AXI4-Lite read side: one read at a time, answered the cycle after.
    assign ARREADY = !RVALID;
    always_comb begin
        rd_ok   = 1'b1;
        rd_next = 32'h00000000;
        unique case (ARADDR)
            A_CTRL: rd_next = ctrl_reg;
            A_SEL:  rd_next = prof ? {24'h000000, sel_reg} : 32'h00000000;
            A_PCFG: rd_next = prof ? sel_prog : 32'h00000000;
            A_SEGL: rd_next = prof ? sel_seg[31:0] : 32'h00000000;
            A_SEGH: rd_next = prof ? sel_seg[63:32] : 32'h00000000;
            A_STAT: rd_next = {6'h00, reps_reg, 1'b0, locked, 2'h0,
                               seg_idx_reg, prg_idx_reg + 4'h1, 1'b0, st_reg};
            A_ELAP: rd_next = {12'h000, elap_reg};
            A_REMS: rd_next = (cur.kind == K_RATE) ? 32'h00000000 : {12'h000, dur_reg - elap_reg};
            A_REMP: rd_next = rem_prog;
            A_SP:   rd_next = {16'h0000, SETPOINT};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            RVALID <= 1'b0;
            RDATA  <= 32'h00000000;
            RRESP  <= 2'h0;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA  <= rd_next;
            RRESP  <= rd_ok ? 2'h0 : 2'h2;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // Remaining program time counts only timed segments; rate ramps are unknown ahead.
    always_comb begin
        logic stop_sum;
        stop_sum = 1'b0;
        rem_prog = (st_reg == S_RUN && cur.kind != K_RATE) ? 32'(dur_reg - elap_reg) : 32'h00000000;
        for (int s = 0; s < NSEG; s++) begin
            if (st_reg == S_RUN && s > int'(seg_idx_reg) && !stop_sum) begin
                if (seg_mem[int'(prg_idx_reg) * NSEG + s].kind == K_END) begin
                    stop_sum = 1'b1;
                end else if (seg_mem[int'(prg_idx_reg) * NSEG + s].kind != K_RATE) begin
                    rem_prog = rem_prog + 32'(dur_sec(seg_mem[int'(prg_idx_reg) * NSEG + s].dur, pcfg.tunit_hm));
                end
            end
        end
    end

    // Time base and button combination.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg     <= 1'b0;
            blink_reg    <= 1'b0;
        end else begin
            tick_reg     <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
            tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : tick_cnt_reg + 32'h1;
            blink_reg    <= tick_reg ? !blink_reg : blink_reg;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ba_sync_reg <= 2'h0;
            bb_sync_reg <= 2'h0;
            both_reg    <= 1'b0;
        end else begin
            ba_sync_reg <= {ba_sync_reg[0], BTN_A};
            bb_sync_reg <= {bb_sync_reg[0], BTN_B};
            both_reg    <= ba_sync_reg[1] & bb_sync_reg[1];
        end
    end
    assign btn_start = ba_sync_reg[1] & bb_sync_reg[1] & !both_reg;

    spseq_lock u_lock (
        .mode   (pcfg.lmode),
        .lockv  (cur.lockv),
        .sp     (sp_reg[23:8]),
        .pv     (PV),
        .locked (locked)
    );

    always_comb begin
        div_num = 32'({delta[16] ? 16'(-delta) : delta[15:0], 8'h00});
        div_den = dur_sec(cur.dur, pcfg.tunit_hm);
        if (cur.kind == K_RATE) begin
            div_num = 32'({cur.rate, 8'h00});
            div_den = pcfg.runit_hr ? SEC_HOUR : SEC_MIN;
        end
    end
    assign div_go = (st_reg == S_LOAD) && (cur.kind == K_TIME || cur.kind == K_RATE);

    spseq_div u_div (
        .clk  (MCLK),
        .rst  (RST),
        .go   (div_go),
        .num  (div_num),
        .den  (div_den),
        .quo  (div_q),
        .done (div_done)
    );

    // Sequencer; while locked the set point and timers hold.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_reg      <= S_STOP;
            prg_idx_reg <= 4'h0;
            seg_idx_reg <= 4'h0;
            reps_reg    <= 10'h000;
            sp_reg      <= 24'h000000;
            step_reg    <= 32'h00000000;
            neg_reg     <= 1'b0;
            elap_reg    <= 20'h00000;
            dur_reg     <= 20'h00000;
        end else if (!prof || ctrl_reg[C_STOP]) begin
            st_reg <= S_STOP;
        end else begin
            unique case (st_reg)
                S_STOP, S_END: begin
                    if (btn_start) begin
                        prg_idx_reg <= cfg_prog;
                        seg_idx_reg <= 4'h0;
                        reps_reg    <= prg_mem[cfg_prog].reps;
                        sp_reg      <= prg_mem[cfg_prog].start_pv ? {PV, 8'h00}
                                       : {prg_mem[cfg_prog].init_sp, 8'h00};
                        st_reg      <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    elap_reg <= 20'h00000;
                    dur_reg  <= dur_sec(cur.dur, pcfg.tunit_hm);
                    neg_reg  <= delta[16];
                    if (cur.kind == K_END) begin
                        if (reps_reg > 10'h001) begin
                            reps_reg    <= reps_reg - 10'h001;
                            seg_idx_reg <= 4'h0;
                            sp_reg      <= pcfg.start_pv ? {PV, 8'h00} : {pcfg.init_sp, 8'h00};
                        end else begin
                            st_reg <= S_END;
                        end
                    end else begin
                        st_reg <= (cur.kind == K_DWELL) ? S_RUN : S_DIV;
                    end
                end
                S_DIV: begin
                    if (div_done) begin
                        step_reg <= div_q;
                        st_reg   <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (tick_reg && !locked) begin
                        elap_reg <= elap_reg + 20'h1;
                        if ((cur.kind != K_RATE && elap_reg + 20'h1 >= dur_reg)
                            || (cur.kind == K_RATE && 32'(delta[16] ? -delta : delta) * 32'h100 <= step_reg)) begin
                            if (cur.kind != K_DWELL) begin
                                sp_reg <= {cur.end_sp, 8'h00};
                            end
                            if (seg_idx_reg == 4'(NSEG - 1)) begin
                                st_reg <= S_END;
                            end else begin
                                seg_idx_reg <= seg_idx_reg + 4'h1;
                                st_reg      <= S_LOAD;
                            end
                        end else if (cur.kind != K_DWELL) begin
                            sp_reg <= neg_reg ? sp_reg - 24'(step_reg) : sp_reg + 24'(step_reg);
                        end
                    end
                end
                default: st_reg <= S_STOP;
            endcase
        end
    end

    // Outputs follow the running segment and keep the end segment after completion.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            aux1_reg     <= 1'b0;
            aux2_reg     <= 1'b0;
            pid_reg      <= 2'h0;
            SETPOINT     <= 16'h0000;
            SP_FROM_PROG <= 1'b0;
            DOT          <= 1'b0;
            PID_SEL      <= 2'h0;
            AUX_OUT      <= 3'h0;
        end else begin
            if (st_reg == S_RUN || st_reg == S_LOAD) begin
                aux1_reg <= cur.aux1;
                aux2_reg <= cur.aux2;
                pid_reg  <= cur.pid;
            end
            SETPOINT     <= sp_reg[23:8];
            SP_FROM_PROG <= prof && st_reg != S_STOP && st_reg != S_END;
            DOT          <= (st_reg == S_RUN || st_reg == S_LOAD || st_reg == S_DIV)
                            && (!locked || blink_reg);
            PID_SEL      <= pid_reg;
            for (int o = 0; o < 3; o++) begin
                AUX_OUT[o] <= (ctrl_reg[C_OUTL + 2*o +: 2] == FN_AUX1) ? aux1_reg
                            : (ctrl_reg[C_OUTL + 2*o +: 2] == FN_AUX2) ? aux2_reg : 1'b0;
            end
        end
    end
endmodule // spseq_top
`default_nettype wire

// File: spseq_props.sv
`timescale 1ns/10ps
`default_nettype none
module spseq_props (
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [7:0]  ARADDR,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        SP_FROM_PROG,
    input wire logic        DOT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    AST_AR_BLOCK: assert property (RVALID |-> !ARREADY) else $error("read taken while data pending");
    AST_AW_BLOCK: assert property (BVALID |-> !AWREADY) else $error("write taken while busy");
    AST_RV_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
    AST_BV_HOLD: assert property (BVALID && !BREADY |=> BVALID) else $error("write response dropped");
    AST_RD_LAT: assert property (ARVALID && ARREADY |=> RVALID) else $error("read answer late");
    AST_WR_LAT: assert property (AWVALID && AWREADY |-> ##[1:3] BVALID)
        else $error("write answer late");
    AST_UNMAP: assert property (ARVALID && ARREADY && ARADDR == 8'h14 |=> RRESP == 2'h2 && RDATA == 32'h0)
        else $error("unmapped read not refused");
    // One cycle of slack, since the dot and the source flag may settle on neighbouring edges.
    AST_DOT_IDLE: assert property (!SP_FROM_PROG [*2] |-> !DOT) else $error("dot lit while idle");
    cover property (RVALID && RRESP == 2'h2);
    cover property ($rose(SP_FROM_PROG));
    cover property (SP_FROM_PROG && $fell(DOT));
endmodule // spseq_props
bind spseq_top spseq_props u_props (.MCLK(MCLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .SP_FROM_PROG(SP_FROM_PROG), .DOT(DOT));
`default_nettype wire

// File: spseq_plant.sv
`timescale 1ns/10ps
`default_nettype none
module spseq_plant (
    input  wire logic        clk,
    input  wire logic [15:0] sp,
    input  wire logic [15:0] dev,
    input  wire logic        press,
    output logic      [15:0] pv,
    output logic             btn_a,
    output logic             btn_b
);
    // The loop settles one cycle behind the set point, offset by a commanded deviation to reach locking.
    always @(posedge clk) pv <= sp + dev;
    // Both keys go down together, after the program has been chosen.
    assign btn_a = press;
    assign btn_b = press;
endmodule // spseq_plant
`default_nettype wire

// File: test_spseq_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_spseq_top
    import spseq_pkg::*;
;
    logic        mclk, rst, awv, wv, bry, arv, rry, awr, wrr, bv, arr, rv, prog, dot, press, ba, bb;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat, st, v;
    logic [1:0]  br, rr, rs, pid;
    logic [2:0]  aux;
    logic [15:0] pv, sp, dev, esp, isp;
    int          bad_count, tests_run, seed;
    spseq_top #(.TICK_CYCLES(10)) DUT (.MCLK(mclk), .RST(rst), .AWVALID(awv), .AWREADY(awr), .AWADDR(awa),
        .WVALID(wv), .WREADY(wrr), .WDATA(wd), .WSTRB(4'hF), .BVALID(bv), .BREADY(bry), .BRESP(br),
        .ARVALID(arv), .ARREADY(arr), .ARADDR(ara), .RVALID(rv), .RREADY(rry), .RDATA(rdat), .RRESP(rr),
        .BTN_A(ba), .BTN_B(bb), .PV(pv), .SETPOINT(sp), .SP_FROM_PROG(prog), .PID_SEL(pid), .AUX_OUT(aux), .DOT(dot));
    spseq_plant u_plant (.clk(mclk), .sp(sp), .dev(dev), .press(press), .pv(pv), .btn_a(ba), .btn_b(bb));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Two short profile runs with polling need a few hundred cycles; this leaves wide margin.
    initial begin
        #300000;
        bad_count++;
        results();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        {arv, rry, ara} <= {2'b11, a};
        do @(posedge mclk); while (!arr);
        arv <= 1'b0;
        do @(posedge mclk); while (!rv);
        {d, rs} = {rdat, rr};
        rry <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {awv, wv, bry, awa, wd} <= {3'b111, a, d};
        do @(posedge mclk); while (!(awr && wrr));
        {awv, wv} <= 2'b00;
        do @(posedge mclk); while (!bv);
        rs = br;
        bry <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (int k = 0; k < 300; k++) begin
            rd(A_STAT, st);
            if (st[2:0] === s) break;
        end
    endtask
    task automatic start(input logic [31:0] cfg, input logic [11:0] lk, input logic [1:0] kd);
        isp = {8'h00, 8'($random(seed))};
        esp = isp + 16'h0100;
        wr(A_SEL, 32'h0000_0000);
        wr(A_PCFG, cfg | {16'h0000, isp});
        wr(A_SEGL, {16'h0003, esp});
        wr(A_SEGH, {kd, 2'h2, 2'h0, lk, 14'h0C00});
        wr(A_SEL, 32'h0000_0001);
        wr(A_SEGH, {2'h3, 2'h1, 2'h3, 12'h000, 14'h0001});
        press <= 1'b1;
        repeat (4) @(posedge mclk);
        press <= 1'b0;
        wait_st(3'h3);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        seed = 22;
        {awv, wv, bry, arv, rry, press, awa, ara, wd, dev} = '0;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(8'h14, v);
        chk(rs, 2'h2);
        wr(8'h14, 32'h0000_0000);
        chk(rs, 2'h2);
        wr(A_SEL, 32'h0000_0012);
        chk(rs, 2'h0);
        wr(A_CTRL, 32'h0000_0911);
        rd(A_SEL, v);
        chk(v, 32'h0000_0000);
        $display("test access done");
        start(32'h0001_0000, 12'h000, 2'h0);
        chk(dot, 1'b1);
        chk(prog, 1'b1);
        chk(pid, 2'h2);
        chk(aux, 3'h0);
        chk(st[7:4], 4'h1);
        wait_st(3'h4);
        chk(sp, esp);
        chk(aux, 3'h3);
        chk(dot, 1'b0);
        chk(prog, 1'b0);
        $display("test profile done");
        dev <= 16'hFF9C;
        start(32'h0C01_0000, 12'h005, 2'h1);
        repeat (40) @(posedge mclk);
        rd(A_STAT, st);
        chk(st[14], 1'b1);
        chk(sp, isp);
        v[0] = dot;
        repeat (10) @(posedge mclk);
        chk(dot, !v[0]);
        dev <= 16'h0000;
        wait_st(3'h4);
        chk(sp, esp);
        $display("test lock done");
        results();
    end
endmodule // test_spseq_top
`default_nettype wire
